// File: hw/dcor_top.sv
// module: register bank for ddc options and overrange detection, with interrupt and pins
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps

// Function
// - alias select picks quarter-rate filter bandwidth
// - half-rate select picks low-pass or high-pass
// - high-pass inverts spectrum; flip can cancel
// - flip only for enabled real output
// - flip negates every odd output sample
// - boost doubles complex output gain only
// - first threshold sets flag bit 0
// - second threshold sets flag bit 1
// - pin enable low holds four pins low
// - embedded flags ignore pin enable
// - pulse lasts at least 8 times 2^n
// - exponent doubles period, resets to seven
// - exponent change with link may shift phase
// - preset mode picks register or pin sources
module dcor_top #(
	parameter int DATA_W = 16
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// register port
	input  wire logic [9:0]          reg_addr_i,
	input  wire logic [7:0]          reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [7:0]          reg_rdata_o,
	// channel samples for overrange detection
	input  wire logic [11:0]         samp_a_i,
	input  wire logic [11:0]         samp_b_i,
	input  wire logic                samp_valid_i,
	// datapath context
	input  wire logic                ddc_enable_i,
	input  wire logic                ddc_complex_i,
	input  wire logic                serial_link_enable_i,
	// converter output stream
	input  wire logic [DATA_W-1:0]   ddc_data_i,
	input  wire logic                ddc_valid_i,
	output logic      [DATA_W-1:0]   ddc_data_o,
	output logic                     ddc_valid_o,
	// filter variant controls
	output logic                     quarter_decim_alias_select_o,
	output logic                     half_decim_highpass_select_o,
	// oscillator preset selection
	input  wire logic [3:0]          preset_select_register_i,
	input  wire logic [1:0]          path_a_preset_pins_i,
	input  wire logic [1:0]          path_b_preset_pins_i,
	output logic      [1:0]          active_preset_a_o,
	output logic      [1:0]          active_preset_b_o,
	// overrange pins and embedded status
	output logic                     chan_a_flag_first_pin_o,
	output logic                     chan_a_flag_second_pin_o,
	output logic                     chan_b_flag_first_pin_o,
	output logic                     chan_b_flag_second_pin_o,
	output logic      [1:0]          embed_flag_a_o,
	output logic      [1:0]          embed_flag_b_o,
	// interrupt
	output logic                     irq_o
);
	import dcor_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] filter_options_ff;  // downconv_filter_options
	logic [7:0] level_first_ff;     // overrange_level_first
	logic [7:0] level_second_ff;    // overrange_level_second
	logic [7:0] pin_config_ff;      // overrange_pin_config
	logic [7:0] preset_source_ff;   // osc_preset_source
	logic [3:0] irq_status_ff;      // sticky events: a0, a1, b0, b1
	logic [3:0] irq_mask_ff;        // one enables the matching status bit
	logic [7:0] rdata_ff;           // read answer, one cycle after strobe

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire sel_filter   = (reg_addr_i == DCOR_OFF_FILTER_OPTIONS);
	wire sel_first    = (reg_addr_i == DCOR_OFF_LEVEL_FIRST);
	wire sel_second   = (reg_addr_i == DCOR_OFF_LEVEL_SECOND);
	wire sel_pin_cfg  = (reg_addr_i == DCOR_OFF_PIN_CONFIG);
	wire sel_preset   = (reg_addr_i == DCOR_OFF_PRESET_SOURCE);
	wire sel_status   = (reg_addr_i == DCOR_OFF_IRQ_STATUS);
	wire sel_mask     = (reg_addr_i == DCOR_OFF_IRQ_MASK);

	// write enables per register
	wire wr_filter    = reg_wr_i && sel_filter;
	wire wr_first     = reg_wr_i && sel_first;
	wire wr_second    = reg_wr_i && sel_second;
	wire wr_pin_cfg   = reg_wr_i && sel_pin_cfg;
	wire wr_preset    = reg_wr_i && sel_preset;
	wire wr_status    = reg_wr_i && sel_status;
	wire wr_mask      = reg_wr_i && sel_mask;

	// ------------------------------------------------------------
	// field views
	// ------------------------------------------------------------
	wire       f_boost     = filter_options_ff[DCOR_BIT_GAIN_BOOST];
	wire       f_flip      = filter_options_ff[DCOR_BIT_SPECTRUM_FLIP];
	wire       f_highpass  = filter_options_ff[DCOR_BIT_HALF_HIGHPASS];
	wire       f_alias     = filter_options_ff[DCOR_BIT_QUARTER_ALIAS];
	wire       pin_enable  = pin_config_ff[DCOR_BIT_PIN_ENABLE];
	wire [2:0] stretch_exp = pin_config_ff[DCOR_LSB_STRETCH_EXP +: 3];
	wire [1:0] preset_mode = preset_source_ff[DCOR_LSB_PRESET_MODE +: 2];

	// ------------------------------------------------------------
	// filter variant selection
	// ------------------------------------------------------------
	// 0: 80% band, over 80 dB; 1: 87.5% band, over 60 dB
	assign quarter_decim_alias_select_o = f_alias;
	// 0: low-pass response; 1: high-pass response
	assign half_decim_highpass_select_o = f_highpass;

	// flip acts only on a real stream out of an enabled converter;
	// with the high-pass response it undoes the inherent inversion
	wire flip_active  = f_flip && ddc_enable_i && !ddc_complex_i;
	// boost is meaningless outside complex decimation, so it is masked
	wire boost_active = f_boost && ddc_enable_i && ddc_complex_i;

	// ------------------------------------------------------------
	// output stream: flip and boost
	// ------------------------------------------------------------
	dcor_stream #(
		.W              (DATA_W)
	) u_stream (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.flip_active_i  (flip_active),
		.boost_active_i (boost_active),
		.data_i         (ddc_data_i),
		.valid_i        (ddc_valid_i),
		.data_o         (ddc_data_o),
		.valid_o        (ddc_valid_o)
	);

	// ------------------------------------------------------------
	// monitoring period divider
	// ------------------------------------------------------------
	logic [DCOR_PERIOD_W-1:0] period_cnt_ff;  // cycles into current period
	logic [2:0]               exp_seen_ff;    // exponent the counter last ran on
	wire  [DCOR_PERIOD_W-1:0] period_last;    // terminal count
	wire                      period_tick;    // one-cycle enable at period end
	wire                      exp_changed;    // exponent written to a new value

	// period is base cycles doubled once per exponent step
	function automatic logic [DCOR_PERIOD_W-1:0] period_end(input logic [2:0] n);
		period_end = DCOR_PERIOD_W'((DCOR_PERIOD_BASE_CYC << n) - 1);
	endfunction : period_end

	assign period_last = period_end(stretch_exp);
	assign period_tick = (period_cnt_ff >= period_last);
	assign exp_changed = (stretch_exp != exp_seen_ff);

	// with the link idle the counter restarts cleanly on a new exponent;
	// with the link running it keeps counting so lane timing is untouched,
	// at the cost of a shifted period phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			period_cnt_ff <= '0;
			exp_seen_ff   <= DCOR_RST_PIN_CONFIG[DCOR_LSB_STRETCH_EXP +: 3];
		end else begin
			exp_seen_ff <= stretch_exp;
			if (exp_changed && !serial_link_enable_i) begin
				period_cnt_ff <= '0;
			end else if (period_tick) begin
				period_cnt_ff <= '0;
			end else begin
				period_cnt_ff <= period_cnt_ff + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// overrange detectors, one per channel
	// ------------------------------------------------------------
	dcor_chan_if chan_a ();
	dcor_chan_if chan_b ();

	assign chan_a.sample      = samp_a_i;
	assign chan_a.valid       = samp_valid_i;
	assign chan_a.thr_first   = level_first_ff;
	assign chan_a.thr_second  = level_second_ff;
	assign chan_a.period_tick = period_tick;
	assign chan_a.pin_enable  = pin_enable;
	assign chan_b.sample      = samp_b_i;
	assign chan_b.valid       = samp_valid_i;
	assign chan_b.thr_first   = level_first_ff;
	assign chan_b.thr_second  = level_second_ff;
	assign chan_b.period_tick = period_tick;
	assign chan_b.pin_enable  = pin_enable;

	dcor_ovr_det u_det_a (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ch    (chan_a)
	);

	dcor_ovr_det u_det_b (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ch    (chan_b)
	);

	// pins are gated inside the detector; embedded flags are not
	assign chan_a_flag_first_pin_o  = chan_a.pin[0];
	assign chan_a_flag_second_pin_o = chan_a.pin[1];
	assign chan_b_flag_first_pin_o  = chan_b.pin[0];
	assign chan_b_flag_second_pin_o = chan_b.pin[1];
	assign embed_flag_a_o           = chan_a.flag_embed;
	assign embed_flag_b_o           = chan_b.flag_embed;

	// ------------------------------------------------------------
	// oscillator preset source
	// ------------------------------------------------------------
	logic [1:0] pins_a_meta_ff;  // first stage, read only by second
	logic [1:0] pins_a_ff;       // synchronised path a pins
	logic [1:0] pins_b_meta_ff;
	logic [1:0] pins_b_ff;       // synchronised path b pins

	// preset pins are asynchronous to the device clock
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pins_a_meta_ff <= 2'h0;
			pins_a_ff      <= 2'h0;
			pins_b_meta_ff <= 2'h0;
			pins_b_ff      <= 2'h0;
		end else begin
			pins_a_meta_ff <= path_a_preset_pins_i;
			pins_a_ff      <= pins_a_meta_ff;
			pins_b_meta_ff <= path_b_preset_pins_i;
			pins_b_ff      <= pins_b_meta_ff;
		end
	end

	logic [1:0] nxt_preset_a;  // chosen preset, path a
	logic [1:0] nxt_preset_b;  // chosen preset, path b

	// reserved mode falls back to the register so the paths stay defined
	always_comb begin
		unique case (dcor_preset_e'(preset_mode))
			DCOR_PRESET_SPLIT_PINS: begin
				nxt_preset_a = pins_a_ff;
				nxt_preset_b = pins_b_ff;
			end
			DCOR_PRESET_SHARED_PINS: begin
				nxt_preset_a = pins_a_ff;
				nxt_preset_b = pins_a_ff;
			end
			DCOR_PRESET_REGISTER, DCOR_PRESET_RESERVED: begin
				nxt_preset_a = preset_select_register_i[1:0];
				nxt_preset_b = preset_select_register_i[3:2];
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_preset_a_o <= 2'h0;
			active_preset_b_o <= 2'h0;
		end else begin
			active_preset_a_o <= nxt_preset_a;
			active_preset_b_o <= nxt_preset_b;
		end
	end

	// ------------------------------------------------------------
	// interrupt: sticky events, write one to clear, set wins
	// ------------------------------------------------------------
	wire [3:0] irq_events = {chan_b.hit, chan_a.hit};
	wire [3:0] irq_clear  = wr_status ? reg_wdata_i[3:0] : 4'h0;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_status_ff <= DCOR_RST_IRQ[3:0];
		end else begin
			irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
		end
	end

	assign irq_o = |(irq_status_ff & irq_mask_ff);

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// reserved fields are stored as written and read back, except status and mask bits 7:4, which read zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			filter_options_ff <= DCOR_RST_FILTER_OPTIONS;
			level_first_ff    <= DCOR_RST_LEVEL_FIRST;
			level_second_ff   <= DCOR_RST_LEVEL_SECOND;
			pin_config_ff     <= DCOR_RST_PIN_CONFIG;
			preset_source_ff  <= DCOR_RST_PRESET_SOURCE;
			irq_mask_ff       <= DCOR_RST_IRQ[3:0];
		end else begin
			if (wr_filter) begin
				filter_options_ff <= reg_wdata_i;
			end
			if (wr_first) begin
				level_first_ff <= reg_wdata_i;
			end
			if (wr_second) begin
				level_second_ff <= reg_wdata_i;
			end
			if (wr_pin_cfg) begin
				pin_config_ff <= reg_wdata_i;
			end
			if (wr_preset) begin
				preset_source_ff <= reg_wdata_i;
			end
			if (wr_mask) begin
				irq_mask_ff <= reg_wdata_i[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	logic [7:0] nxt_rdata;  // selected read value

	// unmapped addresses answer zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (sel_filter) begin
			nxt_rdata = filter_options_ff;
		end else if (sel_first) begin
			nxt_rdata = level_first_ff;
		end else if (sel_second) begin
			nxt_rdata = level_second_ff;
		end else if (sel_pin_cfg) begin
			nxt_rdata = pin_config_ff;
		end else if (sel_preset) begin
			nxt_rdata = preset_source_ff;
		end else if (sel_status) begin
			nxt_rdata = {4'h0, irq_status_ff};
		end else if (sel_mask) begin
			nxt_rdata = {4'h0, irq_mask_ff};
		end
	end

	// data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= reg_rd_i ? nxt_rdata : 8'h00;
		end
	end

	assign reg_rdata_o = rdata_ff;

endmodule : dcor_top

// File: include/dcor_pkg.sv
// package: register map, field layout, reset values and timing for the ddc options block
package dcor_pkg;

	// ------------------------------------------------------------
	// register offsets (register port address)
	// ------------------------------------------------------------
	localparam logic [9:0] DCOR_OFF_FILTER_OPTIONS = 10'h210;  // downconv_filter_options
	localparam logic [9:0] DCOR_OFF_LEVEL_FIRST    = 10'h211;  // overrange_level_first
	localparam logic [9:0] DCOR_OFF_LEVEL_SECOND   = 10'h212;  // overrange_level_second
	localparam logic [9:0] DCOR_OFF_PIN_CONFIG     = 10'h213;  // overrange_pin_config
	localparam logic [9:0] DCOR_OFF_PRESET_SOURCE  = 10'h214;  // osc_preset_source
	localparam logic [9:0] DCOR_OFF_IRQ_STATUS     = 10'h21A;  // sticky overrange events
	localparam logic [9:0] DCOR_OFF_IRQ_MASK       = 10'h21B;  // interrupt mask

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DCOR_RST_FILTER_OPTIONS = 8'h00;
	localparam logic [7:0] DCOR_RST_LEVEL_FIRST    = 8'hF2;
	localparam logic [7:0] DCOR_RST_LEVEL_SECOND   = 8'hAB;
	localparam logic [7:0] DCOR_RST_PIN_CONFIG     = 8'h07;
	localparam logic [7:0] DCOR_RST_PRESET_SOURCE  = 8'h00;
	localparam logic [7:0] DCOR_RST_IRQ            = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DCOR_BIT_GAIN_BOOST     = 0;  // filter options
	localparam int DCOR_BIT_SPECTRUM_FLIP  = 1;
	localparam int DCOR_BIT_HALF_HIGHPASS  = 2;
	localparam int DCOR_BIT_QUARTER_ALIAS  = 3;
	localparam int DCOR_BIT_PIN_ENABLE     = 3;  // pin config
	localparam int DCOR_LSB_STRETCH_EXP    = 0;  // pin config, 3 bits
	localparam int DCOR_LSB_PRESET_MODE    = 0;  // preset source, 2 bits

	// ------------------------------------------------------------
	// timing: monitoring period is base times two to the exponent
	// ------------------------------------------------------------
	localparam int DCOR_PERIOD_BASE_CYC = 8;     // device clock cycles
	localparam int DCOR_PERIOD_W        = 11;    // holds 8 * 2**7 - 1

	// preset source modes
	typedef enum logic [1:0] {
		DCOR_PRESET_REGISTER,
		DCOR_PRESET_SPLIT_PINS,
		DCOR_PRESET_SHARED_PINS,
		DCOR_PRESET_RESERVED
	} dcor_preset_e;

	// top eight bits of magnitude of a 12-bit two's complement sample, full scale 256
	function automatic logic [7:0] dcor_mag8(input logic [11:0] s);
		logic [11:0] a;
		a = s[11] ? 12'(~s + 12'h001) : s;
		dcor_mag8 = (a[11]) ? 8'hFF : a[10:3];
	endfunction : dcor_mag8

endpackage : dcor_pkg

// File: include/dcor_chan_if.sv
// interface: one channel of overrange detection between the register bank and a detector
`timescale 1ns/1ps
interface dcor_chan_if;
	logic [11:0] sample;       // channel sample
	logic        valid;        // sample strobe
	logic [7:0]  thr_first;    // level for flag 0
	logic [7:0]  thr_second;   // level for flag 1
	logic        period_tick;  // last cycle of monitoring period
	logic        pin_enable;   // gate for output pins
	logic [1:0]  flag_embed;   // per-sample status, never gated
	logic [1:0]  pin;          // stretched, gated pin levels
	logic [1:0]  hit;          // detection pulse this cycle

	modport det (input sample, valid, thr_first, thr_second, period_tick, pin_enable,
		output flag_embed, pin, hit);
	modport ctl (output sample, valid, thr_first, thr_second, period_tick, pin_enable,
		input flag_embed, pin, hit);
endinterface : dcor_chan_if

// File: hw/dcor_ovr_det.sv
// module: per-channel threshold compare and overrange pulse stretching
`timescale 1ns/1ps
module dcor_ovr_det (
	input wire logic  clk_i,
	input wire logic  rst_i,
	dcor_chan_if.det  ch
);
	import dcor_pkg::*;

	wire  [7:0] mag;       // scaled magnitude
	wire  [1:0] det;       // threshold reached this cycle
	logic [1:0] embed_ff;  // status riding with data
	logic [1:0] seen_ff;   // any hit in current period
	logic [1:0] pin_ff;    // stretched level before gating

	assign mag = dcor_mag8(ch.sample);
	assign det = ch.valid ? {(mag >= ch.thr_second), (mag >= ch.thr_first)} : 2'h0;

	// ------------------------------------------------------------
	// stretch: pin drops only at a period end with no hit in that period
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			embed_ff <= 2'h0;
			seen_ff  <= 2'h0;
			pin_ff   <= 2'h0;
		end else begin
			if (ch.valid) begin
				embed_ff <= det;
			end
			seen_ff <= ch.period_tick ? det : (seen_ff | det);
			pin_ff  <= ch.period_tick ? (det | seen_ff) : (pin_ff | det);
		end
	end

	assign ch.flag_embed = embed_ff;
	assign ch.pin        = pin_ff & {2{ch.pin_enable}};
	assign ch.hit        = det;
endmodule : dcor_ovr_det

// File: hw/dcor_stream.sv
// module: spectrum flip and complex gain boost on the converter output stream
`timescale 1ns/1ps
module dcor_stream #(
	parameter int W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         flip_active_i,
	input  wire logic         boost_active_i,
	input  wire logic [W-1:0] data_i,
	input  wire logic         valid_i,
	output logic      [W-1:0] data_o,
	output logic              valid_o
);
	localparam logic [W-1:0] MAXP = {1'b0, {(W-1){1'b1}}};  // most positive
	localparam logic [W-1:0] MAXN = {1'b1, {(W-1){1'b0}}};  // most negative

	logic         odd_ff;  // parity of sample index
	wire  [W-1:0] neg;     // saturated negation
	wire  [W-1:0] dbl;     // saturated doubling
	wire  [W-1:0] nxt_data;

	assign neg = (data_i == MAXN) ? MAXP : W'(~data_i + 1'b1);
	// doubling overflows when the two top bits differ: clip instead of wrap
	assign dbl = (data_i[W-1] != data_i[W-2]) ? (data_i[W-1] ? MAXN : MAXP)
		: {data_i[W-2:0], 1'b0};
	assign nxt_data = boost_active_i ? dbl
		: ((flip_active_i && odd_ff) ? neg : data_i);

	// ------------------------------------------------------------
	// output register and sample parity
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			odd_ff  <= 1'b0;
			data_o  <= '0;
			valid_o <= 1'b0;
		end else begin
			valid_o <= valid_i;
			if (valid_i) begin
				odd_ff <= ~odd_ff;
				data_o <= nxt_data;
			end
		end
	end
endmodule : dcor_stream

// File: dv/dcor_top_chk.sv
// checker: assertions on the block's ports
`timescale 1ns/1ps
module dcor_top_chk
	import dcor_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic [9:0]        reg_addr_i,
	input wire logic [7:0]        reg_wdata_i,
	input wire logic              reg_wr_i,
	input wire logic [11:0]       samp_a_i,
	input wire logic              samp_valid_i,
	input wire logic              ddc_enable_i,
	input wire logic [DATA_W-1:0] ddc_data_i,
	input wire logic              ddc_valid_i,
	input wire logic [DATA_W-1:0] ddc_data_o,
	input wire logic              ddc_valid_o,
	input wire logic              quarter_decim_alias_select_o,
	input wire logic              half_decim_highpass_select_o,
	input wire logic              chan_a_flag_first_pin_o,
	input wire logic              chan_a_flag_second_pin_o,
	input wire logic              chan_b_flag_first_pin_o,
	input wire logic              chan_b_flag_second_pin_o,
	input wire logic [1:0]        embed_flag_a_o,
	input wire logic              irq_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// --------------------
	// decoded writes
	// --------------------
	wire wr_opt = reg_wr_i && reg_addr_i == DCOR_OFF_FILTER_OPTIONS;  // filter options
	wire wr_off = reg_wr_i && reg_addr_i == DCOR_OFF_PIN_CONFIG && !reg_wdata_i[3];  // pins off
	wire wr_msk = reg_wr_i && reg_addr_i == DCOR_OFF_IRQ_MASK && reg_wdata_i == 8'h00;
	wire [3:0] pins = {chan_b_flag_second_pin_o, chan_b_flag_first_pin_o,
		chan_a_flag_second_pin_o, chan_a_flag_first_pin_o};
	// --------------------
	// properties
	// --------------------
	property p_alias; wr_opt |=> quarter_decim_alias_select_o == $past(reg_wdata_i[3]); endproperty
	a_alias: assert property (p_alias) else $error("alias select wrong");
	property p_hpass; wr_opt |=> half_decim_highpass_select_o == $past(reg_wdata_i[2]); endproperty
	a_hpass: assert property (p_hpass) else $error("highpass select wrong");
	property p_off; wr_off |=> (pins == 4'h0) [*2]; endproperty
	a_off: assert property (p_off) else $error("pins not held low");
	property p_flag0; samp_valid_i && samp_a_i == 12'h800 |=> embed_flag_a_o[0]; endproperty
	a_flag0: assert property (p_flag0) else $error("first flag missing");
	property p_flag1; samp_valid_i && samp_a_i == 12'h7FF |=> embed_flag_a_o[1]; endproperty
	a_flag1: assert property (p_flag1) else $error("second flag missing");
	// a rise from a hit lasts at least 8 cycles, the shortest period
	property p_hold; $rose(pins[0]) && !$past(reg_wr_i) |-> pins[0] [*8]; endproperty
	a_hold: assert property (p_hold) else $error("pulse too short");
	property p_irq; wr_msk |=> !irq_o; endproperty
	a_irq: assert property (p_irq) else $error("masked interrupt seen");
	property p_byp; ddc_valid_i && !ddc_enable_i |=> ddc_valid_o && ddc_data_o == $past(ddc_data_i);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass word altered");
endmodule : dcor_top_chk

// File: dv/dcor_pin_mon.sv
// partner model: host logic timing the overrange pins
`timescale 1ns/1ps
module dcor_pin_mon (
	input  wire logic       clk_i,       // device clock
	input  wire logic       rst_i,       // async reset
	input  wire logic [3:0] pins_i,      // overrange pins
	output int              last_len_o,  // last pulse length
	output int              pulses_o     // finished pulses
);
	int run;  // cycles high so far
	// --------------------
	// pulse timer over all four pins
	// --------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run <= 0;
			last_len_o <= 0;
			pulses_o <= 0;
		end else if (pins_i != 4'h0) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_len_o <= run;
			pulses_o <= pulses_o + 1;
			run <= 0;
		end
	end
endmodule : dcor_pin_mon

// File: dv/tb.sv
// testbench for the ddc options block
`timescale 1ns/1ps
module tb;
	import dcor_pkg::*;
	logic        clk_i, rst_i, reg_wr_i, reg_rd_i, samp_valid_i, ddc_enable_i, ddc_complex_i;
	logic        serial_link_enable_i, ddc_valid_i, ddc_valid_o, irq_o;
	logic        quarter_decim_alias_select_o, half_decim_highpass_select_o;
	logic        chan_a_flag_first_pin_o, chan_a_flag_second_pin_o;
	logic        chan_b_flag_first_pin_o, chan_b_flag_second_pin_o;
	logic [9:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o, rv, v8;
	logic [11:0] samp_a_i, samp_b_i;
	logic [15:0] ddc_data_i, ddc_data_o;
	logic [3:0]  preset_select_register_i, ps;
	logic [1:0]  path_a_preset_pins_i, path_b_preset_pins_i, active_preset_a_o, active_preset_b_o;
	logic [1:0]  embed_flag_a_o, embed_flag_b_o, fo, pa, pb;
	int          num_errors, compares, nw, len, np;
	logic [9:0]  ra [8] = '{10'h210, 10'h211, 10'h212, 10'h213, 10'h214, 10'h21A, 10'h21B, 10'h215};
	logic [7:0]  rr [8] = '{8'h00, 8'hF2, 8'hAB, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
	dcor_top i_dut (.*);
	dcor_pin_mon i_mon (.clk_i, .rst_i, .last_len_o(len), .pulses_o(np),
		.pins_i({chan_b_flag_second_pin_o, chan_b_flag_first_pin_o,
		chan_a_flag_second_pin_o, chan_a_flag_first_pin_o}));
	// --------------------
	// bus tasks and comparison
	// --------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	// data stand one cycle after the strobe
	task automatic rd(input logic [9:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rv = reg_rdata_o;
		@(posedge clk_i);
	endtask : rd
	task automatic samp(input logic [11:0] a, input logic [11:0] b);
		samp_a_i <= a;
		samp_b_i <= b;
		samp_valid_i <= 1'b1;
		@(posedge clk_i);
		samp_valid_i <= 1'b0;
		@(posedge clk_i);
	endtask : samp
	// stream word and model; parity counts all words
	task automatic sw(input logic [15:0] d);
		int v;
		v = $signed(d);
		if (ddc_enable_i && ddc_complex_i && fo[0]) v = 2 * v;
		else if (ddc_enable_i && !ddc_complex_i && fo[1] && nw % 2) v = -v;
		v = v > 32767 ? 32767 : v < -32768 ? -32768 : v;
		nw++;
		ddc_data_i <= d;
		ddc_valid_i <= 1'b1;
		@(posedge clk_i);
		ddc_valid_i <= 1'b0;
		#1 chk({ddc_valid_o, ddc_data_o}, {1'b1, 16'(v)});
		@(posedge clk_i);
	endtask : sw
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	// --------------------
	// clock, watchdog, tests
	// --------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#50us;
		num_errors++;
		stop_test();
	end
	initial begin
		{reg_wr_i, reg_rd_i, samp_valid_i, ddc_enable_i, ddc_complex_i, ddc_valid_i} = '0;
		{serial_link_enable_i, reg_addr_i, reg_wdata_i, samp_a_i, samp_b_i, ddc_data_i} = '0;
		{preset_select_register_i, path_a_preset_pins_i, path_b_preset_pins_i} = '0;
		{num_errors, compares, nw, fo} = '0;
		rst_i = 1'b1;
		void'($urandom(32'h9A19));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rv, rr[i]);
			v8 = 8'($urandom);
			wr(ra[i], v8);
			rd(ra[i]);
			chk(rv, i == 6 ? v8 & 8'h0F : i > 4 ? 8'h00 : v8);
		end
		for (int m = 0; m < 4; m++) begin
			{ps, pa, pb} = 8'($urandom);
			{preset_select_register_i, path_a_preset_pins_i, path_b_preset_pins_i} <= {ps, pa, pb};
			wr(DCOR_OFF_PRESET_SOURCE, 8'(m));
			repeat (4) @(posedge clk_i);
			chk(active_preset_a_o, m == 1 || m == 2 ? pa : ps[1:0]);
			chk(active_preset_b_o, m == 1 ? pb : m == 2 ? pa : ps[3:2]);
		end
		wr(10'h21A, 8'h0F);
		wr(10'h21B, 8'h0F);
		wr(10'h211, 8'h10);
		wr(10'h212, 8'hAB);
		wr(10'h213, 8'h08);
		samp(12'h080, 12'h07F);
		chk({embed_flag_b_o, embed_flag_a_o}, 4'h1);
		repeat (24) @(posedge clk_i);
		chk({np, len >= 8}, {32'd1, 1'b1});
		rd(10'h21A);
		chk({rv, irq_o}, {8'h01, 1'b1});
		wr(10'h21A, 8'h01);
		chk(irq_o, 1'b0);
		serial_link_enable_i <= 1'b1;
		wr(10'h213, 8'h0A);
		samp(12'h7FF, 12'h800);
		chk({embed_flag_b_o, embed_flag_a_o}, 4'hF);
		repeat (80) @(posedge clk_i);
		chk({np, len >= 32}, {32'd2, 1'b1});
		rd(10'h21A);
		chk(rv, 8'h0F);
		wr(10'h21B, 8'h00);
		chk(irq_o, 1'b0);
		wr(10'h21B, 8'h0F);
		chk(irq_o, 1'b1);
		wr(10'h21A, 8'h0F);
		wr(10'h213, 8'h02);
		samp(12'h800, 12'h800);
		chk({embed_flag_b_o, embed_flag_a_o}, 4'hF);
		repeat (40) @(posedge clk_i);
		chk({np, i_mon.run}, {32'd2, 32'd0});
		for (int k = 0; k < 16; k++) begin
			ddc_enable_i <= k[3];
			ddc_complex_i <= k[2];
			fo = k[1:0];
			wr(DCOR_OFF_FILTER_OPTIONS, 8'(k));
			chk({quarter_decim_alias_select_o, half_decim_highpass_select_o}, k[3:2]);
			sw(16'($urandom));
			sw(16'h8000);
			sw(16'h7FFF);
		end
		stop_test();
	end
endmodule : tb
bind dcor_top dcor_top_chk #(.DATA_W(DATA_W)) u_chk (.*);
